// File: design/acmp_regs.svh
// register offsets, fields, reset values and timing counts
`ifndef ACMP_REGS_SVH
`define ACMP_REGS_SVH
`define ACMP_ADDR_CTRL      12'h097
`define ACMP_ADDR_STAT      12'h098
`define ACMP_ADDR_PORT3     12'h099
`define ACMP_CTRL_RESET     8'h00
`define ACMP_PORT3_RESET    8'hff
`define ACMP_MIRROR_BIT     6
`define ACMP_IRQ_EN_BIT     6
`define ACMP_COND_LSB       0
`define ACMP_COND_MSB       2
`define ACMP_ON_BIT         3
`define ACMP_FLAG_BIT       4
`define ACMP_KEEP_IDLE_BIT  5
`define ACMP_SETTLE_NS      10000
`define ACMP_CLK_MHZ        40
`define ACMP_SETTLE_CYC     ((`ACMP_SETTLE_NS * `ACMP_CLK_MHZ + 999) / 1000)
`define ACMP_OVF_WAIT       2
`endif

// File: design/acmp_pkg.sv
// types for the comparator event logic
package acmp_pkg;
  typedef enum logic [2:0]
  {
    ACMP_LOW_LEVEL  = 3'h0,
    ACMP_RISE       = 3'h1,
    ACMP_TOGGLE_DB  = 3'h2,
    ACMP_RISE_DB    = 3'h3,
    ACMP_FALL       = 3'h4,
    ACMP_TOGGLE     = 3'h5,
    ACMP_FALL_DB    = 3'h6,
    ACMP_HIGH_LEVEL = 3'h7
  } acmp_cond_type;
  typedef enum logic [1:0]
  {
    ACMP_DB_IDLE  = 2'b00,
    ACMP_DB_WAIT1 = 2'b01,
    ACMP_DB_WAIT2 = 2'b11
  } acmp_db_state_type;
endpackage

// File: design/acmp_debounce.sv
// debounce wait on two timer overflows, then resample
`timescale 1ns/1ps
`include "acmp_regs.svh"
module acmp_debounce
  import acmp_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic active_i,
  input  wire logic start_i,
  input  wire logic expect_i,
  input  wire logic sample_i,
  input  wire logic ovf_i,
  output logic      hit_o,
  output logic      busy_o
);
  acmp_db_state_type state_q;
  logic              expect_q;

  assign busy_o = (state_q != ACMP_DB_IDLE);

  always_ff @(posedge clk_i)
  begin
    hit_o <= 1'b0;
    if (!reset_n_i || !active_i)
    begin
      state_q  <= ACMP_DB_IDLE;
      expect_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ACMP_DB_IDLE:
        begin
          if (start_i)
          begin
            state_q  <= ACMP_DB_WAIT1;
            expect_q <= expect_i;
          end
        end
        ACMP_DB_WAIT1:
        begin
          if (ovf_i)
            state_q <= ACMP_DB_WAIT2;
        end
        ACMP_DB_WAIT2:
        begin
          if (ovf_i)
          begin
            state_q <= ACMP_DB_IDLE;
            hit_o   <= (sample_i == expect_q);
          end
        end
        default:
          state_q <= ACMP_DB_IDLE;
      endcase
    end
  end

  chk_db_resample: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    (state_q == ACMP_DB_WAIT2 && ovf_i && active_i) |=>
      (hit_o == (expect_q == $past(sample_i))) && !busy_o)
    else $error("debounce resample result wrong");
  chk_db_two_ovf: assert property (@(posedge clk_i)
    disable iff (!reset_n_i)
    (state_q == ACMP_DB_WAIT1) |=> !hit_o)
    else $error("debounce ended before second overflow");
endmodule // acmp_debounce

// File: design/acmp_event_top.sv
// comparator event logic with APB register access
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "acmp_regs.svh"
module acmp_event_top
  import acmp_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  input  wire logic        COMPARE_RAW_I,
  input  wire logic        T1_OVF_I,
  input  wire logic        IDLE_I,
  input  wire logic        POWER_DOWN_I,
  input  wire logic [7:0]  PORT3_PINS_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  output logic             COMPARE_IRQ_O,
  output logic             WAKE_O,
  output logic [7:0]       PORT3_LATCH_O
);
  import acmp_pkg::*;

  logic [2:0] cond_q;
  logic       comparator_on_q;
  logic       match_event_flag_q;
  logic       keep_running_in_idle_q;
  logic       compare_irq_enable_q;
  logic [7:0] port3_q;
  logic       cmp_s1_q;
  logic       cmp_s2_q;
  logic [7:0] pins_s1_all_q;
  logic [7:0] pins_s2_q;
  logic       sample_q;
  logic       prev_q;
  logic       active;
  logic       sample_live;
  logic       rise;
  logic       fall;
  logic       plain_hit;
  logic       db_start;
  logic       db_expect;
  logic       db_hit;
  logic       db_busy;
  logic       set_flag;
  logic       wr_acc;
  logic       rd_acc;
  logic       hit_ctrl;
  logic       hit_stat;
  logic       hit_port;
  logic [7:0] ctrl_view;
  logic [7:0] pin_view;

  function automatic logic is_debounced(input logic [2:0] c);
    return (c == ACMP_TOGGLE_DB) || (c == ACMP_RISE_DB)
        || (c == ACMP_FALL_DB);
  endfunction

  // byte address is the register index times four
  function automatic logic addr_is(input logic [11:0] a,
                                   input logic [11:0] idx);
    return a == (idx << 2);
  endfunction

  // comparator powered only when enabled and not gated by sleep modes
  assign active = comparator_on_q && !POWER_DOWN_I
               && (!IDLE_I || keep_running_in_idle_q);
  // raw input is high exactly when plus exceeds minus
  assign sample_live = active && cmp_s2_q;

  // two-flop synchronisers for comparator and pins
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      cmp_s1_q      <= 1'b0;
      cmp_s2_q      <= 1'b0;
      pins_s1_all_q <= 8'h00;
      pins_s2_q     <= 8'h00;
    end
    else
    begin
      cmp_s1_q      <= COMPARE_RAW_I;
      cmp_s2_q      <= cmp_s1_q;
      pins_s1_all_q <= PORT3_PINS_I;
      pins_s2_q     <= pins_s1_all_q;
    end
  end

  // one sample per clock; previous sample kept for edges
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      sample_q <= 1'b0;
      prev_q   <= 1'b0;
    end
    else
    begin
      sample_q <= sample_live;
      prev_q   <= sample_q;
    end
  end

  assign rise = active && sample_q && !prev_q;
  assign fall = active && !sample_q && prev_q;

  // condition decode; debounced codes hand off to the wait
  always_comb
  begin
    plain_hit = 1'b0;
    db_start  = 1'b0;
    db_expect = 1'b0;
    unique case (acmp_cond_type'(cond_q))
      ACMP_LOW_LEVEL:  plain_hit = active && !sample_q;
      ACMP_HIGH_LEVEL: plain_hit = active && sample_q;
      ACMP_RISE:       plain_hit = rise;
      ACMP_FALL:       plain_hit = fall;
      ACMP_TOGGLE:     plain_hit = rise || fall;
      ACMP_RISE_DB:
      begin
        db_start  = rise && !db_busy;
        db_expect = 1'b1;
      end
      ACMP_FALL_DB:
      begin
        db_start  = fall && !db_busy;
        db_expect = 1'b0;
      end
      ACMP_TOGGLE_DB:
      begin
        db_start  = (rise || fall) && !db_busy;
        db_expect = sample_q;
      end
    endcase
  end

  acmp_debounce u_debounce
  (
    .clk_i     (CLK_I),
    .reset_n_i (RESET_N_I),
    .active_i  (active && is_debounced(cond_q)),
    .start_i   (db_start),
    .expect_i  (db_expect),
    .sample_i  (sample_q),
    .ovf_i     (T1_OVF_I),
    .hit_o     (db_hit),
    .busy_o    (db_busy)
  );

  assign set_flag = active && (plain_hit || db_hit);

  // apb decode, zero wait states
  assign wr_acc   = PSEL_I && PENABLE_I && PWRITE_I;
  assign rd_acc   = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign hit_ctrl = addr_is(PADDR_I, `ACMP_ADDR_CTRL);
  assign hit_stat = addr_is(PADDR_I, `ACMP_ADDR_STAT);
  assign hit_port = addr_is(PADDR_I, `ACMP_ADDR_PORT3);

  // register writes land at the access edge
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      cond_q                 <= 3'h0;
      comparator_on_q        <= 1'b0;
      keep_running_in_idle_q <= 1'b0;
      compare_irq_enable_q   <= 1'b0;
      port3_q                <= `ACMP_PORT3_RESET;
    end
    else if (wr_acc)
    begin
      if (hit_ctrl)
      begin
        cond_q                 <= PWDATA_I[`ACMP_COND_MSB:`ACMP_COND_LSB];
        comparator_on_q        <= PWDATA_I[`ACMP_ON_BIT];
        keep_running_in_idle_q <= PWDATA_I[`ACMP_KEEP_IDLE_BIT];
      end
      if (hit_stat)
        compare_irq_enable_q <= PWDATA_I[`ACMP_IRQ_EN_BIT];
      if (hit_port)
        port3_q <= PWDATA_I[7:0];
    end
  end

  // flag: hardware set wins over software clear
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
      match_event_flag_q <= 1'b0;
    else if (set_flag)
      match_event_flag_q <= 1'b1;
    else if (wr_acc && hit_ctrl)
      match_event_flag_q <= PWDATA_I[`ACMP_FLAG_BIT];
  end

  assign ctrl_view = {2'b00, keep_running_in_idle_q, match_event_flag_q,
                      comparator_on_q, cond_q};
  assign pin_view  = {pins_s2_q[7], sample_q, pins_s2_q[5:0]};

  // registered response, one access cycle per transfer
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      PRDATA_O  <= 32'h0;
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
    end
    else
    begin
      PREADY_O  <= PSEL_I && !PENABLE_I;
      PSLVERR_O <= PSEL_I && !PENABLE_I
                && !(hit_ctrl || hit_stat || hit_port);
      if (rd_acc)
        PRDATA_O <= hit_ctrl ? {24'h0, ctrl_view}
                  : hit_stat ? {25'h0, compare_irq_enable_q, 6'h00}
                  : hit_port ? {24'h0, pin_view} : 32'h0;
      else
        PRDATA_O <= 32'h0;
    end
  end

  // interrupt, wake and latch levels
  always_ff @(posedge CLK_I)
  begin
    if (!RESET_N_I)
    begin
      COMPARE_IRQ_O <= 1'b0;
      WAKE_O        <= 1'b0;
      PORT3_LATCH_O <= `ACMP_PORT3_RESET;
    end
    else
    begin
      COMPARE_IRQ_O <= match_event_flag_q && compare_irq_enable_q;
      WAKE_O        <= IDLE_I && keep_running_in_idle_q
                    && match_event_flag_q && compare_irq_enable_q;
      PORT3_LATCH_O <= port3_q;
    end
  end

  chk_irq_gated: assert property (@(posedge CLK_I)
    disable iff (!RESET_N_I)
    COMPARE_IRQ_O |-> $past(compare_irq_enable_q))
    else $error("irq without enable");

  chk_flag_off: assert property (@(posedge CLK_I)
    disable iff (!RESET_N_I)
    (!comparator_on_q && !(wr_acc && hit_ctrl)) |=>
    (match_event_flag_q == $past(match_event_flag_q) || !match_event_flag_q))
    else $error("flag set while disabled");

  chk_flag_sticky: assert property (@(posedge CLK_I)
    disable iff (!RESET_N_I)
    (match_event_flag_q && !(wr_acc && hit_ctrl)) |=> match_event_flag_q)
    else $error("flag dropped without clear");

  chk_level_high: assert property (@(posedge CLK_I)
    disable iff (!RESET_N_I)
    (active && cond_q == 3'h7 && sample_q) |=> match_event_flag_q)
    else $error("high level missed");

  chk_rise_edge: assert property (@(posedge CLK_I)
    disable iff (!RESET_N_I)
    (active && cond_q == 3'h1 && sample_q && !prev_q) |=> match_event_flag_q)
    else $error("rising edge missed");

  chk_pd_off: assert property (@(posedge CLK_I)
    disable iff (!RESET_N_I)
    POWER_DOWN_I |=> !sample_q)
    else $error("comparator live in power-down");

  chk_idle_off: assert property (@(posedge CLK_I)
    disable iff (!RESET_N_I)
    (IDLE_I && !keep_running_in_idle_q) |=> !sample_q)
    else $error("comparator live in idle");

  chk_wake_irq: assert property (@(posedge CLK_I)
    disable iff (!RESET_N_I)
    WAKE_O |-> COMPARE_IRQ_O)
    else $error("wake without irq");
endmodule // acmp_event_top

// File: testbench/acmp_analog_model.sv
// analog comparator and timer 1 overflow model
`timescale 1ns/1ps
module acmp_analog_model
#(
  parameter int T1_PERIOD = 20
)
(
  input  wire logic       clk_i,
  input  wire logic [7:0] plus_input_i,
  input  wire logic [7:0] minus_input_i,
  input  wire logic       t1_run_i,
  output logic            compare_raw_o,
  output logic            t1_ovf_o
);
  int t1_count_q = 0;
  // equal inputs give zero
  assign compare_raw_o = (plus_input_i > minus_input_i);
  assign t1_ovf_o      = t1_run_i && (t1_count_q == T1_PERIOD - 1);
  // timer restarts from zero while stopped
  always_ff @(posedge clk_i)
  begin
    if (!t1_run_i || t1_ovf_o)
      t1_count_q <= 0;
    else
      t1_count_q <= t1_count_q + 1;
  end
endmodule // acmp_analog_model

// File: testbench/test_acmp_event_top.sv
// register level tests of the comparator event logic
`timescale 1ns/1ps
`include "acmp_regs.svh"
module test_acmp_event_top;
  import acmp_pkg::*;
  localparam int T1P = 20;
  localparam logic [11:0] A_CTRL = `ACMP_ADDR_CTRL << 2;
  localparam logic [11:0] A_STAT = `ACMP_ADDR_STAT << 2;
  localparam logic [11:0] A_P3   = `ACMP_ADDR_PORT3 << 2;
  logic        clk = 0, reset_n = 0, idle = 0, pd = 0, t1_run = 0;
  logic        psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        pready, pslverr, irq, wake, raw, ovf;
  logic [7:0]  latch, plus = 8'h40, minus = 8'h80, pins = 8'ha5;
  int          bad_count = 0, cmp_count = 0, cycles = 0;
  acmp_cond_type c;
  acmp_cond_type edges [3] = '{ACMP_RISE, ACMP_FALL, ACMP_TOGGLE};
  acmp_cond_type dbs [3] = '{ACMP_RISE_DB, ACMP_FALL_DB, ACMP_TOGGLE_DB};

  acmp_analog_model #(.T1_PERIOD(T1P)) i_model
  (.clk_i(clk), .plus_input_i(plus), .minus_input_i(minus),
   .t1_run_i(t1_run), .compare_raw_o(raw), .t1_ovf_o(ovf));
  acmp_event_top i_dut
  (.CLK_I(clk), .RESET_N_I(reset_n), .COMPARE_RAW_I(raw), .T1_OVF_I(ovf),
   .IDLE_I(idle), .POWER_DOWN_I(pd), .PORT3_PINS_I(pins), .PSEL_I(psel),
   .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
   .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
   .PSLVERR_O(pslverr), .COMPARE_IRQ_O(irq), .WAKE_O(wake),
   .PORT3_LATCH_O(latch));

  always #12.5 clk = ~clk;

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      $display("ERROR timeout");
      stop_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  // one apb transfer; ready, data and error taken at the same edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input string n, input logic [11:0] a,
                     input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask

  function automatic logic [31:0] cv(int k, f, o, logic [2:0] m);
    return {26'h0, k[0], f[0], o[0], m};
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic lvl(input logic h, input int n);
    @(posedge clk);
    plus  <= h ? 8'h80 : 8'h40;
    minus <= h ? 8'h40 : 8'h80;
    cyc(n);
  endtask

  initial
  begin
    cyc(8);
    reset_n <= 1'b1;
    rdc("ctrl reset", A_CTRL, 32'h0);
    rdc("pins reset", A_P3, 32'ha5);
    chk("latch reset", {24'h0, latch}, 32'hff);
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped err", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    $display("test reset done");
    lvl(1'b1, 6);
    apb(1'b1, A_CTRL, cv(0, 0, 0, ACMP_HIGH_LEVEL));
    cyc(8);
    rdc("off flag", A_CTRL, cv(0, 0, 0, ACMP_HIGH_LEVEL));
    rdc("off mirror", A_P3, 32'ha5);
    apb(1'b1, A_CTRL, cv(0, 0, 1, ACMP_HIGH_LEVEL));
    cyc(`ACMP_SETTLE_CYC);
    rdc("high level", A_CTRL, cv(0, 1, 1, ACMP_HIGH_LEVEL));
    apb(1'b1, A_CTRL, cv(0, 0, 1, ACMP_HIGH_LEVEL));
    rdc("level again", A_CTRL, cv(0, 1, 1, ACMP_HIGH_LEVEL));
    apb(1'b1, A_P3, 32'h40);
    cyc(2);
    chk("latch write", {24'h0, latch}, 32'h40);
    rdc("mirror high", A_P3, 32'he5);
    @(posedge clk);
    minus <= plus;
    cyc(6);
    rdc("equal inputs", A_P3, 32'ha5);
    pins <= 8'h5a;
    cyc(4);
    rdc("pin 6 masked", A_P3, 32'h1a);
    $display("test level done");
    foreach (edges[i])
    begin
      c = edges[i];
      lvl(1'b0, 6);
      apb(1'b1, A_CTRL, cv(0, 0, 1, c));
      lvl(1'b1, 6);
      rdc("rise", A_CTRL, cv(0, c != ACMP_FALL, 1, c));
      apb(1'b1, A_CTRL, cv(0, 0, 1, c));
      lvl(1'b0, 6);
      rdc("fall", A_CTRL, cv(0, c != ACMP_RISE, 1, c));
    end
    $display("test edges done");
    apb(1'b1, A_CTRL, cv(0, 0, 1, ACMP_RISE));
    lvl(1'b1, 30);
    rdc("flag held", A_CTRL, cv(0, 1, 1, ACMP_RISE));
    chk("irq masked", {31'h0, irq}, 32'h0);
    apb(1'b1, A_STAT, 32'h40);
    rdc("irq enable", A_STAT, 32'h40);
    cyc(3);
    chk("irq on", {31'h0, irq}, 32'h1);
    apb(1'b1, A_CTRL, cv(0, 0, 1, ACMP_RISE));
    cyc(3);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test irq done");
    foreach (dbs[i])
    begin
      c = dbs[i];
      lvl(c == ACMP_FALL_DB, 6);
      apb(1'b1, A_CTRL, cv(0, 0, 1, c));
      lvl(c != ACMP_FALL_DB, 0);
      t1_run <= 1'b1;
      cyc(T1P + 4);
      rdc("one overflow", A_CTRL, cv(0, 0, 1, c));
      cyc(T1P);
      rdc("two overflows", A_CTRL, cv(0, 1, 1, c));
      t1_run <= 1'b0;
    end
    apb(1'b1, A_CTRL, cv(0, 0, 1, ACMP_RISE_DB));
    lvl(1'b0, 6);
    lvl(1'b1, 0);
    t1_run <= 1'b1;
    cyc(4);
    lvl(1'b0, 2 * T1P + 4);
    rdc("bounce dropped", A_CTRL, cv(0, 0, 1, ACMP_RISE_DB));
    t1_run <= 1'b0;
    $display("test debounce done");
    idle <= 1'b1;
    apb(1'b1, A_CTRL, cv(0, 0, 1, ACMP_LOW_LEVEL));
    cyc(6);
    rdc("idle off", A_CTRL, cv(0, 0, 1, ACMP_LOW_LEVEL));
    apb(1'b1, A_CTRL, cv(1, 0, 1, ACMP_LOW_LEVEL));
    cyc(6);
    chk("wake", {31'h0, wake}, 32'h1);
    rdc("idle keep", A_CTRL, cv(1, 1, 1, ACMP_LOW_LEVEL));
    pd <= 1'b1;
    apb(1'b1, A_CTRL, cv(1, 0, 1, ACMP_LOW_LEVEL));
    cyc(6);
    rdc("power down", A_CTRL, cv(1, 0, 1, ACMP_LOW_LEVEL));
    $display("test power done");
    stop_test();
  end
endmodule // test_acmp_event_top
